// >>> ttis_pkg.sv
package ttis_pkg;
	// opcodes
	localparam logic [7:0] OP_COPY_ACC_TO_INDEX    = 8'h97;
	localparam logic [7:0] OP_COPY_FLAGS_TO_ACC    = 8'h85;
	localparam logic [7:0] OP_TEST_DIR             = 8'h3d;
	localparam logic [7:0] OP_TEST_ACC             = 8'h4d;
	localparam logic [7:0] OP_TEST_IDX             = 8'h5d;
	localparam logic [7:0] OP_TEST_IX1             = 8'h6d;
	localparam logic [7:0] OP_TEST_IX              = 8'h7d;
	localparam logic [7:0] OP_PREFIX_SP            = 8'h9e;
	localparam logic [7:0] OP_COPY_SP_TO_PAIR      = 8'h95;
	localparam logic [7:0] OP_COPY_IDX_TO_ACC      = 8'h9f;
	localparam logic [7:0] OP_COPY_PAIR_TO_SP      = 8'h94;
	// cycle counts
	localparam logic [2:0] CYC_INH1 = 3'h1;
	localparam logic [2:0] CYC_INH2 = 3'h2;
	localparam logic [2:0] CYC_IX   = 3'h2;
	localparam logic [2:0] CYC_DIR  = 3'h3;
	localparam logic [2:0] CYC_IX1  = 3'h3;
	localparam logic [2:0] CYC_SP1  = 3'h4;
	// flag bit positions in the condition code register
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_N = 2;
	localparam int FLG_V = 7;
	// reset values
	localparam logic [7:0]  RST_FLAGS = 8'h60;
	localparam logic [15:0] RST_SP  = 16'h00ff;
	typedef enum logic [1:0] {
		TTIS_IDLE = 2'b00,
		TTIS_PREF = 2'b01,
		TTIS_BUSY = 2'b10
	} ttis_state_t;
	typedef enum logic [2:0] {
		TTIS_OP_NONE  = 3'b000,
		TTIS_OP_SP_TO_PAIR = 3'b001,
		TTIS_OP_PAIR_TO_SP = 3'b010,
		TTIS_OP_MEM_TEST   = 3'b011
	} ttis_op_t;
endpackage

// >>> ttis_flags.sv
`timescale 1ns/10ps
// flag update for a value minus zero: v cleared, n and z from value
module ttis_flags (
	input  wire logic [7:0] flags_in,
	input  wire logic [7:0] value,
	output logic      [7:0] flags_out
);
	always_comb begin
		flags_out = flags_in;
		flags_out[ttis_pkg::FLG_V] = 1'b0;
		flags_out[ttis_pkg::FLG_N] = value[7];
		flags_out[ttis_pkg::FLG_Z] = (value == 8'h00);
	end
endmodule

// >>> ttis_core.sv
`timescale 1ns/10ps
// How it works
// - opcode 97 copies the accumulator into the index low byte in one cycle, flags untouched.
// - opcode 85 loads the accumulator from the condition codes in one cycle, flags untouched.
// - the zero test clears v and sets n and z from the value; 4d tests acc, 5d tests index, one cycle each.
// - 7d indexed no offset takes two cycles; prefix 9e then 6d, stack offset form, takes four.
// - opcode 95 loads the index pair with stack pointer plus one in two cycles, flags untouched.
// - opcode 9f copies the index low byte into the accumulator in one cycle, flags untouched.
// - opcode 94 loads the stack pointer with index pair minus one in two cycles, flags untouched.
module ttis_core (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic        op_valid,
	input  wire logic [7:0]  op_byte,
	output logic             op_ready,
	input  wire logic [7:0]  mem_data,
	output logic             done,
	output logic             illegal,
	output logic [7:0]       acc,
	output logic [15:0]      index_pair,
	output logic [15:0]      stack_ptr,
	output logic [7:0]       condition_code_register
);
	typedef struct packed {
		ttis_pkg::ttis_state_t st;
		ttis_pkg::ttis_op_t    op;
		logic [2:0]            cnt;
		logic                  done;
		logic                  ill;
		logic [7:0]            a;
		logic [15:0]           hx;
		logic [15:0]           sp;
		logic [7:0]            flags;
	} ttis_regs_t;

	ttis_regs_t r_q;
	ttis_regs_t r_d;
	logic [7:0] test_src;
	logic [7:0] flags_test;

	////////////////////////////////////////////////////////////////
	// shared flag update for every zero test form
	ttis_flags u_flags (
		.flags_in  (r_q.flags),
		.value     (test_src),
		.flags_out (flags_test)
	);

	always_comb begin
		if (r_q.st == ttis_pkg::TTIS_BUSY) test_src = mem_data;
		else if (op_byte == ttis_pkg::OP_TEST_IDX) test_src = r_q.hx[7:0];
		else test_src = r_q.a;
	end

	assign op_ready = (r_q.st != ttis_pkg::TTIS_BUSY);

	////////////////////////////////////////////////////////////////
	// decode and execute
	always_comb begin
		r_d      = r_q;
		r_d.done = 1'b0;
		r_d.ill  = 1'b0;
		unique case (r_q.st)
			ttis_pkg::TTIS_IDLE: begin
				if (op_valid) begin
					unique case (op_byte)
						ttis_pkg::OP_COPY_ACC_TO_INDEX: begin
							r_d.hx[7:0] = r_q.a;
							r_d.done    = 1'b1;
						end
						ttis_pkg::OP_COPY_FLAGS_TO_ACC: begin
							r_d.a    = r_q.flags;
							r_d.done = 1'b1;
						end
						ttis_pkg::OP_COPY_IDX_TO_ACC: begin
							r_d.a    = r_q.hx[7:0];
							r_d.done = 1'b1;
						end
						ttis_pkg::OP_TEST_ACC, ttis_pkg::OP_TEST_IDX: begin
							r_d.flags = flags_test;
							r_d.done = 1'b1;
						end
						ttis_pkg::OP_COPY_SP_TO_PAIR: begin
							r_d.st  = ttis_pkg::TTIS_BUSY;
							r_d.op  = ttis_pkg::TTIS_OP_SP_TO_PAIR;
							r_d.cnt = ttis_pkg::CYC_INH2 - 3'h1;
						end
						ttis_pkg::OP_COPY_PAIR_TO_SP: begin
							r_d.st  = ttis_pkg::TTIS_BUSY;
							r_d.op  = ttis_pkg::TTIS_OP_PAIR_TO_SP;
							r_d.cnt = ttis_pkg::CYC_INH2 - 3'h1;
						end
						ttis_pkg::OP_TEST_DIR, ttis_pkg::OP_TEST_IX1: begin
							r_d.st  = ttis_pkg::TTIS_BUSY;
							r_d.op  = ttis_pkg::TTIS_OP_MEM_TEST;
							r_d.cnt = ttis_pkg::CYC_DIR - 3'h1;
						end
						ttis_pkg::OP_TEST_IX: begin
							r_d.st  = ttis_pkg::TTIS_BUSY;
							r_d.op  = ttis_pkg::TTIS_OP_MEM_TEST;
							r_d.cnt = ttis_pkg::CYC_IX - 3'h1;
						end
						ttis_pkg::OP_PREFIX_SP: begin
							r_d.st = ttis_pkg::TTIS_PREF;
						end
						default: begin
							r_d.ill  = 1'b1;
							r_d.done = 1'b1;
						end
					endcase
				end
			end
			ttis_pkg::TTIS_PREF: begin
				if (op_valid) begin
					if (op_byte == ttis_pkg::OP_TEST_IX1) begin
						// prefix counted as the first of four cycles
						r_d.st  = ttis_pkg::TTIS_BUSY;
						r_d.op  = ttis_pkg::TTIS_OP_MEM_TEST;
						r_d.cnt = ttis_pkg::CYC_SP1 - 3'h2;
					end else begin
						r_d.st   = ttis_pkg::TTIS_IDLE;
						r_d.ill  = 1'b1;
						r_d.done = 1'b1;
					end
				end
			end
			ttis_pkg::TTIS_BUSY: begin
				if (r_q.cnt == 3'h1) begin
					r_d.st   = ttis_pkg::TTIS_IDLE;
					r_d.done = 1'b1;
					r_d.op   = ttis_pkg::TTIS_OP_NONE;
					unique case (r_q.op)
						ttis_pkg::TTIS_OP_SP_TO_PAIR: r_d.hx    = r_q.sp + 16'h0001;
						ttis_pkg::TTIS_OP_PAIR_TO_SP: r_d.sp    = r_q.hx - 16'h0001;
						ttis_pkg::TTIS_OP_MEM_TEST:   r_d.flags = flags_test;
						default: ;
					endcase
				end
				r_d.cnt = r_q.cnt - 3'h1;
			end
			default: r_d.st = ttis_pkg::TTIS_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			r_q      <= '0;
			r_q.flags <= ttis_pkg::RST_FLAGS;
			r_q.sp   <= ttis_pkg::RST_SP;
		end else begin
			r_q <= r_d;
		end
	end

	assign done                    = r_q.done;
	assign illegal                 = r_q.ill;
	assign acc                     = r_q.a;
	assign index_pair              = r_q.hx;
	assign stack_ptr               = r_q.sp;
	assign condition_code_register = r_q.flags;

	////////////////////////////////////////////////////////////////
	// checks
	sequence s_issue(logic [7:0] code);
		op_valid && op_ready && r_q.st == ttis_pkg::TTIS_IDLE && op_byte == code;
	endsequence

	property p_acc_to_index;
		@(posedge clk_sys) disable iff (!arst_n)
		s_issue(ttis_pkg::OP_COPY_ACC_TO_INDEX) |=> done && index_pair[7:0] == $past(acc) && $stable(condition_code_register);
	endproperty
	a_acc_to_index: assert property (p_acc_to_index) else $error("acc to index copy wrong");

	property p_flags_to_acc;
		@(posedge clk_sys) disable iff (!arst_n)
		s_issue(ttis_pkg::OP_COPY_FLAGS_TO_ACC) |=> done && acc == $past(condition_code_register) && $stable(condition_code_register);
	endproperty
	a_flags_to_acc: assert property (p_flags_to_acc) else $error("flags to acc copy wrong");

	property p_acc_test;
		@(posedge clk_sys) disable iff (!arst_n)
		s_issue(ttis_pkg::OP_TEST_ACC) |=> done && !condition_code_register[ttis_pkg::FLG_V]
			&& condition_code_register[ttis_pkg::FLG_Z] == ($past(acc) == 8'h00)
			&& condition_code_register[ttis_pkg::FLG_N] == $past(acc[7]);
	endproperty
	a_acc_test: assert property (p_acc_test) else $error("acc test flags wrong");

	property p_dir_test;
		@(posedge clk_sys) disable iff (!arst_n)
		s_issue(ttis_pkg::OP_TEST_DIR) |=> !done ##1 !done ##1 done && !condition_code_register[ttis_pkg::FLG_V];
	endproperty
	a_dir_test: assert property (p_dir_test) else $error("direct test not three cycles");

	property p_ix_test;
		@(posedge clk_sys) disable iff (!arst_n)
		s_issue(ttis_pkg::OP_TEST_IX) |=> !done ##1 done;
	endproperty
	a_ix_test: assert property (p_ix_test) else $error("indexed test not two cycles");

	property p_sp_test;
		@(posedge clk_sys) disable iff (!arst_n)
		s_issue(ttis_pkg::OP_PREFIX_SP) ##1 (op_valid && op_byte == ttis_pkg::OP_TEST_IX1)
			|=> !done ##1 !done ##1 done;
	endproperty
	a_sp_test: assert property (p_sp_test) else $error("stack test not four cycles");

	property p_sp_to_pair;
		@(posedge clk_sys) disable iff (!arst_n)
		s_issue(ttis_pkg::OP_COPY_SP_TO_PAIR) |=> !done ##1 done && index_pair == $past(stack_ptr, 2) + 16'h0001
			&& condition_code_register == $past(condition_code_register, 2);
	endproperty
	a_sp_to_pair: assert property (p_sp_to_pair) else $error("stack to pair wrong");

	property p_index_to_acc;
		@(posedge clk_sys) disable iff (!arst_n)
		s_issue(ttis_pkg::OP_COPY_IDX_TO_ACC) |=> done && acc == $past(index_pair[7:0]) && $stable(condition_code_register);
	endproperty
	a_index_to_acc: assert property (p_index_to_acc) else $error("index to acc copy wrong");

	property p_pair_to_sp;
		@(posedge clk_sys) disable iff (!arst_n)
		s_issue(ttis_pkg::OP_COPY_PAIR_TO_SP) |=> !done ##1 done && stack_ptr == $past(index_pair, 2) - 16'h0001
			&& condition_code_register == $past(condition_code_register, 2);
	endproperty
	a_pair_to_sp: assert property (p_pair_to_sp) else $error("pair to stack wrong");
endmodule

// >>> ttis_prog_mem.sv
`timescale 1ns/10ps
// program memory model: offers opcode bytes and the memory operand
module ttis_prog_mem (
	input  wire logic       clk_sys,
	input  wire logic       op_ready,
	output logic            op_valid,
	output logic      [7:0] op_byte,
	output logic      [7:0] mem_data
);
	logic [7:0] operand;
	// quiet bus at time zero
	initial begin
		op_valid = 1'b0;
		op_byte  = 8'h00;
		operand  = 8'h00;
		mem_data = 8'h00;
	end
	// operand only while the core is busy, its inverse otherwise
	always @(negedge clk_sys) begin
		mem_data <= (op_ready === 1'b0) ? operand : ~operand;
	end
	////////////////////////////////////////////////////////////////
	// offer a byte after gap edges, hold it until the taking edge
	task automatic send(input logic [7:0] b, input int gap);
		repeat (gap) @(posedge clk_sys);
		op_valid <= 1'b1;
		op_byte  <= b;
		@(negedge clk_sys);
		while (op_ready !== 1'b1) @(negedge clk_sys);
		@(posedge clk_sys);
	endtask
	// drop the request; stale byte is scrambled
	task automatic idle();
		op_valid <= 1'b0;
		op_byte  <= ~op_byte;
	endtask
endmodule

// >>> ttis_tb.sv
`timescale 1ns/10ps
// self-checking bench for the transfer and zero-test group
module testbench;
	logic        clk_sys;
	logic        arst_n;
	logic        op_valid;
	logic [7:0]  op_byte;
	logic        op_ready;
	logic [7:0]  mem_data;
	logic        done;
	logic        illegal;
	logic [7:0]  acc;
	logic [15:0] index_pair;
	logic [15:0] stack_ptr;
	logic [7:0]  cond_reg;
	logic [7:0]  e_acc;
	logic [15:0] e_ix;
	logic [15:0] e_sp;
	logic [7:0]  e_cond;
	int          n_fail;
	int          n_checks;
	// free-running clock
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;
	ttis_core dut (.clk_sys(clk_sys), .arst_n(arst_n), .op_valid(op_valid), .op_byte(op_byte),
		.op_ready(op_ready), .mem_data(mem_data), .done(done), .illegal(illegal), .acc(acc),
		.index_pair(index_pair), .stack_ptr(stack_ptr), .condition_code_register(cond_reg));
	ttis_prog_mem pm (.clk_sys(clk_sys), .op_ready(op_ready), .op_valid(op_valid), .op_byte(op_byte),
		.mem_data(mem_data));
	////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic check_state();
		check("acc", {8'h00, acc}, {8'h00, e_acc});
		check("index_pair", index_pair, e_ix);
		check("stack_ptr", stack_ptr, e_sp);
		check("cond_reg", {8'h00, cond_reg}, {8'h00, e_cond});
	endtask
	// expected effect of one instruction
	task automatic apply(input logic [7:0] b, input logic [7:0] m);
		logic [7:0] v;
		v = m;
		case (b)
			ttis_pkg::OP_COPY_ACC_TO_INDEX: e_ix[7:0] = e_acc;
			ttis_pkg::OP_COPY_FLAGS_TO_ACC: e_acc = e_cond;
			ttis_pkg::OP_COPY_IDX_TO_ACC:   e_acc = e_ix[7:0];
			ttis_pkg::OP_COPY_SP_TO_PAIR:   e_ix = e_sp + 16'h0001;
			ttis_pkg::OP_COPY_PAIR_TO_SP:   e_sp = e_ix - 16'h0001;
			ttis_pkg::OP_TEST_ACC:          v = e_acc;
			ttis_pkg::OP_TEST_IDX:          v = e_ix[7:0];
			default: ;
		endcase
		if (b inside {8'h3d, 8'h4d, 8'h5d, 8'h6d, 8'h7d}) begin
			e_cond[ttis_pkg::FLG_V] = 1'b0;
			e_cond[ttis_pkg::FLG_N] = v[7];
			e_cond[ttis_pkg::FLG_Z] = (v == 8'h00);
		end
	endtask
	// one instruction: timing to done, illegal flag, resulting state
	task automatic op(input logic [7:0] b, input logic pre, input logic [7:0] m, input int gap,
		input int cyc, input logic ill);
		int n;
		pm.operand = m;
		if (pre) pm.send(8'h9e, gap);
		pm.send(b, pre ? 0 : gap);
		pm.idle();
		n = 1;
		@(negedge clk_sys);
		while (done !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		check("cycles", 16'(n), 16'(cyc));
		check("illegal", {15'h0000, illegal}, {15'h0000, ill});
		if (!ill) apply(b, m);
		check_state();
	endtask
	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_transfers();
		op(8'h85, 1'b0, 8'h00, 1, 1, 1'b0);
		op(8'h95, 1'b0, 8'h00, 3, 2, 1'b0);
		op(8'h5d, 1'b0, 8'h00, 1, 1, 1'b0);
		op(8'h97, 1'b0, 8'h00, 1, 1, 1'b0);
		op(8'h94, 1'b0, 8'h00, 1, 2, 1'b0);
		$display("test transfers done");
	endtask
	task automatic t_test();
		op(8'h3d, 1'b0, 8'h80, 1, 3, 1'b0);
		op(8'h6d, 1'b0, 8'h00, 2, 3, 1'b0);
		op(8'h5d, 1'b0, 8'h00, 1, 1, 1'b0);
		op(8'h7d, 1'b0, 8'h00, 1, 2, 1'b0);
		op(8'h6d, 1'b1, 8'h80, 1, 3, 1'b0);
		op(8'h85, 1'b0, 8'h00, 1, 1, 1'b0);
		op(8'h4d, 1'b0, 8'h00, 1, 1, 1'b0);
		op(8'h9f, 1'b0, 8'h00, 1, 1, 1'b0);
		$display("test zero test done");
	endtask
	task automatic t_illegal();
		op(8'h00, 1'b0, 8'h00, 1, 1, 1'b1);
		op(8'h4d, 1'b1, 8'h00, 1, 1, 1'b1);
		$display("test illegal done");
	endtask
	// byte offered while the core is busy must wait its turn
	task automatic t_b2b();
		op(8'h3d, 1'b0, 8'h00, 1, 3, 1'b0);
		pm.send(8'h85, 1);
		pm.send(8'h97, 0);
		pm.send(8'h95, 0);
		pm.send(8'h9f, 0);
		pm.idle();
		apply(8'h85, 8'h00);
		apply(8'h97, 8'h00);
		apply(8'h95, 8'h00);
		apply(8'h9f, 8'h00);
		repeat (4) @(negedge clk_sys);
		check_state();
		$display("test back to back done");
	endtask
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		arst_n   = 1'b0;
		n_fail   = 0;
		n_checks = 0;
		e_acc    = 8'h00;
		e_ix     = 16'h0000;
		e_sp     = ttis_pkg::RST_SP;
		e_cond   = ttis_pkg::RST_FLAGS;
		repeat (8) @(negedge clk_sys);
		check_state();
		check("op_ready", {15'h0000, op_ready}, 16'h0001);
		@(posedge clk_sys);
		arst_n <= 1'b1;
		$display("test reset done");
		t_transfers();
		t_test();
		t_illegal();
		t_b2b();
		give_verdict();
	end
	// watchdog well beyond the fewer than a hundred cycles the tests need
	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end
endmodule
